// ==== hdl/egress_queue_ratio_scheduler.sv ====
/*
  Egress transmit_queue scheduler for port 1 queues 0/1 and port 2 queues 2/3,
  with the two ratio registers reachable over a classic Wishbone slave.
  Assumes a single core clock, synchronous inputs, and that the transmit
  logic drops a queue's pending flag once its grant has been consumed.
*/
`timescale 1ns/1ns
module egress_queue_ratio_scheduler #(
  parameter int PERIOD_CYCLES = egress_queue_pkg::PERIOD_CYCLES_DEFAULT
) (
  // Clock and reset.
  input  wire logic                                ref_clk_in,
  input  wire logic                                reset_n_in,
  // Wishbone slave.
  input  wire logic                                wb_cyc_in,
  input  wire logic                                wb_stb_in,
  input  wire logic                                wb_we_in,
  input  wire logic [egress_queue_pkg::ADDR_W-1:0] wb_adr_in,
  input  wire logic [3:0]                          wb_sel_in,
  input  wire logic [egress_queue_pkg::DATA_W-1:0] wb_dat_in,
  output logic      [egress_queue_pkg::DATA_W-1:0] wb_dat_out,
  output logic                                     wb_ack_out,
  // Transmit side.
  input  wire logic [3:0]                          queue_pending_in,
  input  wire logic                                p1_upper_pending_in,
  input  wire logic [1:0]                          port_ready_in,
  output logic      [3:0]                          grant_out
);
  import egress_queue_pkg::*;

  localparam int PERIOD_W = $clog2(PERIOD_CYCLES + 1);
  localparam logic [PERIOD_W-1:0] PERIOD_LAST = PERIOD_W'(PERIOD_CYCLES - 1);
  localparam logic [PERIOD_W-1:0] PERIOD_ZERO = '0;
  localparam logic [RATIO_W-1:0]  COUNT_MAX   = '1;

  typedef struct packed {
    logic [REG_W-1:0]                   p1_ratio;
    logic [REG_W-1:0]                   p2_ratio;
    logic [NUM_QUEUES-1:0][RATIO_W-1:0] sent;
    logic [PERIOD_W-1:0]                period;
    logic                               ack;
    logic [DATA_W-1:0]                  rdata;
    logic [NUM_QUEUES-1:0]              grant;
  } state_t;

  localparam state_t RESET_STATE = '{
    p1_ratio: PORT1_LOW_RESET,
    p2_ratio: PORT2_HIGH_RESET,
    sent:     '0,
    period:   PERIOD_ZERO,
    ack:      1'b0,
    rdata:    '0,
    grant:    '0
  };

  state_t st;
  state_t next_st;

  // Byte-lane merge of a 16-bit register with the low half of the write data.
  function automatic logic [REG_W-1:0] merge_lanes(input logic [REG_W-1:0] old,
                                                   input logic [DATA_W-1:0] wd,
                                                   input logic [3:0] sel);
    logic [REG_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Mode bit of queue q; even queues live in the upper half of their register.
  function automatic logic mode_of(input logic [REG_W-1:0] p1, input logic [REG_W-1:0] p2,
                                   input int q);
    logic [REG_W-1:0] r;
    r = (q < 2) ? p1 : p2;
    return (q % 2 == 0) ? r[HI_MODE_BIT] : r[LO_MODE_BIT];
  endfunction

  // Packet-count field of queue q.
  function automatic logic [RATIO_W-1:0] ratio_of(input logic [REG_W-1:0] p1,
                                                  input logic [REG_W-1:0] p2,
                                                  input int q);
    logic [REG_W-1:0] r;
    r = (q < 2) ? p1 : p2;
    return (q % 2 == 0) ? r[HI_RATIO_LSB +: RATIO_W] : r[LO_RATIO_LSB +: RATIO_W];
  endfunction

  // Next-state logic: register file, period timer, counters and arbitration.
  always_comb begin
    logic                  period_end;
    logic                  bus_req;
    logic [INDEX_W-1:0]    idx;
    logic [NUM_QUEUES-1:0] higher_busy;
    logic [NUM_QUEUES-1:0] eligible;
    logic [NUM_QUEUES-1:0] pick;
    logic [1:0]            port_free;
    next_st     = st;
    period_end  = (st.period == PERIOD_LAST);
    bus_req     = wb_cyc_in && wb_stb_in && !st.ack;
    idx         = wb_adr_in[ADDR_W-1:2];
    higher_busy = '0;
    eligible    = '0;
    pick        = '0;
    port_free   = '0;

    // Wishbone: answer one cycle after the strobe; unmapped reads give zero.
    next_st.ack   = bus_req;
    next_st.rdata = '0;
    if (bus_req && wb_we_in) begin
      if (idx == PORT1_LOW_QUEUE_RATIO_IDX) begin
        next_st.p1_ratio = merge_lanes(st.p1_ratio, wb_dat_in, wb_sel_in);
      end
      if (idx == PORT2_HIGH_QUEUE_RATIO_IDX) begin
        next_st.p2_ratio = merge_lanes(st.p2_ratio, wb_dat_in, wb_sel_in);
      end
    end
    if (bus_req && !wb_we_in) begin
      if (idx == PORT1_LOW_QUEUE_RATIO_IDX) begin
        next_st.rdata = {{(DATA_W-REG_W){1'b0}}, st.p1_ratio};
      end
      if (idx == PORT2_HIGH_QUEUE_RATIO_IDX) begin
        next_st.rdata = {{(DATA_W-REG_W){1'b0}}, st.p2_ratio};
      end
      if (idx == SENT_COUNT_STATUS_IDX) begin
        next_st.rdata = {{(DATA_W-NUM_QUEUES*RATIO_W){1'b0}}, st.sent};
      end
    end

    // A queue in strict mode waits for every higher queue of its port.
    higher_busy[0] = queue_pending_in[1] || p1_upper_pending_in;
    higher_busy[1] = p1_upper_pending_in;
    higher_busy[2] = queue_pending_in[3];
    higher_busy[3] = 1'b0;
    for (int q = 0; q < NUM_QUEUES; q++) begin
      if (mode_of(st.p1_ratio, st.p2_ratio, q)) begin
        // Ratio mode: spend the per-period credit.
        eligible[q] = queue_pending_in[q] &&
                      (st.sent[q] < ratio_of(st.p1_ratio, st.p2_ratio, q));
      end else begin
        eligible[q] = queue_pending_in[q] && !higher_busy[q];
      end
    end

    // One grant per port, never in two adjacent cycles, so that the pending
    // flag has time to fall before the same queue is looked at again.
    port_free[0] = port_ready_in[0] && !(st.grant[0] || st.grant[1]);
    port_free[1] = port_ready_in[1] && !(st.grant[2] || st.grant[3]);
    pick[1] = port_free[0] && eligible[1];
    pick[0] = port_free[0] && eligible[0] && !eligible[1];
    pick[3] = port_free[1] && eligible[3];
    pick[2] = port_free[1] && eligible[2] && !eligible[3];
    next_st.grant = pick;

    // Period timer and sent counters; a grant in the last cycle counts anew.
    next_st.period = period_end ? PERIOD_ZERO : st.period + PERIOD_W'(1);
    for (int q = 0; q < NUM_QUEUES; q++) begin
      next_st.sent[q] = period_end ? '0 : st.sent[q];
      if (pick[q] && next_st.sent[q] != COUNT_MAX) begin
        next_st.sent[q] = next_st.sent[q] + RATIO_W'(1); // Saturates in strict mode.
      end
    end
  end

  // State register; reset loads the documented defaults.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_out = st.rdata;
  assign wb_ack_out = st.ack;
  assign grant_out  = st.grant;

  // Helper state that only the assertions read.
  logic started;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_p1q0_strict_wait: assert property (
    grant_out[0] && !$past(st.p1_ratio[HI_MODE_BIT])
      |-> !$past(queue_pending_in[1]) && !$past(p1_upper_pending_in))
    else $error("Strict queue 0 granted while a higher queue waited.");

  a_p1q0_ratio_limit: assert property (
    grant_out[0] && $past(st.p1_ratio[HI_MODE_BIT])
      |-> $past(st.sent[0]) < $past(st.p1_ratio[HI_RATIO_LSB +: RATIO_W]))
    else $error("Queue 0 exceeded its packet count.");

  a_p1_reset_value: assert property (
    !started |-> st.p1_ratio[HI_RATIO_LSB +: RATIO_W] == Q0_RATIO_RESET
                 && st.p1_ratio[LO_RATIO_LSB +: RATIO_W] == Q1_RATIO_RESET)
    else $error("Port 1 count fields wrong after reset.");

  a_p1q1_strict_wait: assert property (
    grant_out[1] && !$past(st.p1_ratio[LO_MODE_BIT]) |-> !$past(p1_upper_pending_in))
    else $error("Strict queue 1 granted while an upper queue waited.");

  a_p1q1_ratio_limit: assert property (
    grant_out[1] && $past(st.p1_ratio[LO_MODE_BIT])
      |-> $past(st.sent[1]) < $past(st.p1_ratio[LO_RATIO_LSB +: RATIO_W]))
    else $error("Queue 1 exceeded its packet count.");

  a_p2q2_strict_wait: assert property (
    grant_out[2] && !$past(st.p2_ratio[HI_MODE_BIT]) |-> !$past(queue_pending_in[3]))
    else $error("Strict queue 2 granted while queue 3 waited.");

  a_p2q2_ratio_limit: assert property (
    grant_out[2] && $past(st.p2_ratio[HI_MODE_BIT])
      |-> $past(st.sent[2]) < $past(st.p2_ratio[HI_RATIO_LSB +: RATIO_W]))
    else $error("Queue 2 exceeded its packet count.");

  a_p2q3_strict_serve: assert property (
    queue_pending_in[3] && !st.p2_ratio[LO_MODE_BIT] && port_ready_in[1]
      && !(grant_out[2] || grant_out[3]) |=> grant_out[3])
    else $error("Strict queue 3 not served on a free port.");

  a_p2_reset_value: assert property (
    !started |-> st.p2_ratio[HI_RATIO_LSB +: RATIO_W] == Q2_RATIO_RESET
                 && st.p2_ratio[LO_RATIO_LSB +: RATIO_W] == Q3_RATIO_RESET)
    else $error("Port 2 count fields wrong after reset.");

  a_mode_reset_ones: assert property (
    !started |-> st.p1_ratio[HI_MODE_BIT] && st.p1_ratio[LO_MODE_BIT]
                 && st.p2_ratio[HI_MODE_BIT] && st.p2_ratio[LO_MODE_BIT])
    else $error("Mode bits not set after reset.");

  a_period_clear: assert property (
    st.period == PERIOD_LAST |=> st.period == PERIOD_ZERO && st.sent[3] == {6'h00, grant_out[3]})
    else $error("Sent counter not cleared at period start.");

  a_bus_ack_once: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("Bus acknowledge held for two cycles.");

  // Every fresh request is answered after exactly one cycle.
  a_ack_after_req: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out
      |=> wb_ack_out)
    else $error("Bus request not acknowledged after one cycle.");

  // An acknowledge never appears without a request in the cycle before.
  a_ack_needs_req: assert property (
    wb_ack_out
      |-> $past(wb_cyc_in && wb_stb_in))
    else $error("Bus acknowledge without a request.");

  // Read data is zero outside the acknowledge cycle, so stale words never leak.
  a_idle_data_zero: assert property (
    !wb_ack_out
      |-> wb_dat_out == '0)
    else $error("Read data not zero outside acknowledge.");

  // A full two-lane write to the port 1 register lands at the taking edge.
  a_p1_write_lands: assert property (
    wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[1:0] == 2'b11
      && wb_adr_in[ADDR_W-1:2] == PORT1_LOW_QUEUE_RATIO_IDX |=> st.p1_ratio == $past(wb_dat_in[REG_W-1:0]))
    else $error("Port 1 register write did not land.");

  // A full two-lane write to the port 2 register lands at the taking edge.
  a_p2_write_lands: assert property (
    wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[1:0] == 2'b11
      && wb_adr_in[ADDR_W-1:2] == PORT2_HIGH_QUEUE_RATIO_IDX |=> st.p2_ratio == $past(wb_dat_in[REG_W-1:0]))
    else $error("Port 2 register write did not land.");

  // Port 1 never grants both of its queues in one cycle.
  a_port1_single: assert property (
    !(grant_out[0] && grant_out[1]))
    else $error("Port 1 granted two queues at once.");

  // Port 2 never grants both of its queues in one cycle.
  a_port2_single: assert property (
    !(grant_out[2] && grant_out[3]))
    else $error("Port 2 granted two queues at once.");

  // A port 1 grant is followed by a quiet cycle so the pending flag can fall.
  a_port1_spacing: assert property (
    grant_out[0] || grant_out[1]
      |=> !(grant_out[0] || grant_out[1]))
    else $error("Port 1 granted in two adjacent cycles.");

  // A port 2 grant is followed by a quiet cycle so the pending flag can fall.
  a_port2_spacing: assert property (
    grant_out[2] || grant_out[3]
      |=> !(grant_out[2] || grant_out[3]))
    else $error("Port 2 granted in two adjacent cycles.");

  // Port 1 grants only when its transmitter was ready.
  a_p1_needs_ready: assert property (
    grant_out[1:0] != 2'b00
      |-> $past(port_ready_in[0]))
    else $error("Port 1 granted while not ready.");

  // Port 2 grants only when its transmitter was ready.
  a_p2_needs_ready: assert property (
    grant_out[3:2] != 2'b00
      |-> $past(port_ready_in[1]))
    else $error("Port 2 granted while not ready.");

  // No queue is granted unless it had a packet waiting.
  a_grant_needs_pending: assert property (
    (grant_out & ~$past(queue_pending_in)) == 4'h0)
    else $error("Grant given to an empty queue.");

  // Queue 3 in ratio mode never exceeds its packet count.
  a_p2q3_ratio_limit: assert property (
    grant_out[3] && $past(st.p2_ratio[LO_MODE_BIT])
      |-> $past(st.sent[3]) < $past(st.p2_ratio[LO_RATIO_LSB +: RATIO_W]))
    else $error("Queue 3 exceeded its packet count.");

  // The period timer steps by one until it wraps.
  a_period_step: assert property (
    st.period != PERIOD_LAST
      |=> st.period == $past(st.period) + PERIOD_W'(1))
    else $error("Period timer did not step by one.");

  // Inside a period each queue 0 grant adds one to its sent counter, which holds at COUNT_MAX.
  a_sent_counts_grant: assert property (
    st.period != PERIOD_LAST && st.sent[0] != COUNT_MAX
      |=> st.sent[0] == $past(st.sent[0]) + {6'h00, grant_out[0]})
    else $error("Queue 0 sent counter does not follow its grants.");

endmodule

// ==== hdl/egress_queue_pkg.sv ====
/*
  Constants shared by the egress queue ratio scheduler: register indexes,
  field positions, reset values and bus widths.
  Assumes a classic Wishbone bus with 32-bit data; each 16-bit register
  sits in the low half of one aligned word at byte address four times its index.
*/
package egress_queue_pkg;

  // Bus geometry.
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          INDEX_W    = 10;

  // Register indexes; the byte address is four times the index.
  localparam logic [INDEX_W-1:0] PORT1_LOW_QUEUE_RATIO_IDX  = 10'h0CA;
  localparam logic [INDEX_W-1:0] PORT2_HIGH_QUEUE_RATIO_IDX = 10'h0CC;
  localparam logic [INDEX_W-1:0] SENT_COUNT_STATUS_IDX      = 10'h0E0;

  // Field layout of a ratio register: even queue in bits 15..8, odd queue in 7..0.
  localparam int          REG_W         = 16;
  localparam int          RATIO_W       = 7;
  localparam int          HI_MODE_BIT   = 15;
  localparam int          HI_RATIO_LSB  = 8;
  localparam int          LO_MODE_BIT   = 7;
  localparam int          LO_RATIO_LSB  = 0;
  localparam int          NUM_QUEUES    = 4;

  // Reset values of the packet-count fields and the mode bits.
  localparam logic [RATIO_W-1:0] Q0_RATIO_RESET = 7'h01;
  localparam logic [RATIO_W-1:0] Q1_RATIO_RESET = 7'h02;
  localparam logic [RATIO_W-1:0] Q2_RATIO_RESET = 7'h04;
  localparam logic [RATIO_W-1:0] Q3_RATIO_RESET = 7'h08;
  localparam logic               MODE_RESET     = 1'b1;

  localparam logic [REG_W-1:0] PORT1_LOW_RESET  =
    {MODE_RESET, Q0_RATIO_RESET, MODE_RESET, Q1_RATIO_RESET};
  localparam logic [REG_W-1:0] PORT2_HIGH_RESET =
    {MODE_RESET, Q2_RATIO_RESET, MODE_RESET, Q3_RATIO_RESET};

  // Default length of one scheduling period in core clock cycles.
  localparam int          PERIOD_CYCLES_DEFAULT = 1024;

endpackage

// ==== sim/egress_queue_ratio_scheduler_bench.sv ====
/*
  Self-checking bench for the egress queue ratio scheduler: register reset values,
  byte-lane writes, an unmapped read, and grant counts per period for each mode.
  Assumes the design package is compiled first and a short period for simulation.
*/
`timescale 1ns/1ns
module egress_queue_ratio_scheduler_bench;
  import egress_queue_pkg::*;

  localparam int P = 128;
  localparam logic [15:0] P1_CFG [5] = '{16'h8182, 16'h8385, 16'h0000, 16'h8000, 16'h8182};
  localparam logic [15:0] P2_CFG [5] = '{16'h8488, 16'h8A00, 16'h0000, 16'h0088, 16'h8488};
  localparam logic        UP     [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [1:0]  RDY    [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1};
  // An entry of FF means unlimited: more than eight grants in the window.
  localparam logic [7:0]  EXP [5][4] = '{'{8'h01, 8'h02, 8'h04, 8'h08},
                                         '{8'h03, 8'h05, 8'h00, 8'hFF},
                                         '{8'h00, 8'h00, 8'h00, 8'hFF},
                                         '{8'h00, 8'hFF, 8'h00, 8'h08},
                                         '{8'h01, 8'h02, 8'h00, 8'h00}};

  logic              ref_clk_in          = 1'b0;
  logic              reset_n_in          = 1'b0;
  logic              wb_cyc_in           = 1'b0;
  logic              wb_stb_in           = 1'b0;
  logic              wb_we_in            = 1'b0;
  logic [ADDR_W-1:0] wb_adr_in           = 12'h000;
  logic [3:0]        wb_sel_in           = 4'h0;
  logic [DATA_W-1:0] wb_dat_in           = 32'h0;
  logic [DATA_W-1:0] wb_dat_out;
  logic              wb_ack_out;
  logic [3:0]        queue_pending_in    = 4'h0;
  logic              p1_upper_pending_in = 1'b0;
  logic [1:0]        port_ready_in       = 2'h3;
  logic [3:0]        grant_out;
  logic [DATA_W-1:0] rd;
  logic              counting            = 1'b0;
  int                failures            = 0;
  int                n_checks            = 0;
  int                cyc_cnt;
  int                cnt [4];

  egress_queue_ratio_scheduler #(.PERIOD_CYCLES(P)) uut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .queue_pending_in(queue_pending_in), .p1_upper_pending_in(p1_upper_pending_in),
    .port_ready_in(port_ready_in), .grant_out(grant_out));

  // A 4 ns clock for the 250 MHz core.
  always #2 ref_clk_in = ~ref_clk_in;

  // Cycle count since release, used to keep each window clear of a period boundary.
  always @(posedge ref_clk_in) begin
    cyc_cnt <= reset_n_in ? cyc_cnt + 1 : 0;
    if (counting) begin
      for (int q = 0; q < 4; q++) begin
        if (grant_out[q] === 1'b1) cnt[q]++;
      end
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One classic Wishbone cycle; the wait for ack is bounded so a silent slave fails.
  task wb_xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
               input logic [3:0] s, output logic [31:0] q);
    int i;
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= we;
    wb_adr_in <= a; wb_sel_in <= s; wb_dat_in <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_in);
      if (wb_ack_out === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      test_done;
    end
    q = wb_dat_out;
    wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0; wb_we_in <= 1'b0;
  endtask

  // Programs one configuration, keeps every queue busy inside a single period, then
  // compares the grant count of each queue; configuration 0 runs on reset values.
  task run_cfg(input int i);
    int k;
    if (i > 0) begin
      wb_xfer(1'b1, 12'h328, {16'h0, P1_CFG[i]}, 4'hF, rd);
      wb_xfer(1'b1, 12'h330, {16'h0, P2_CFG[i]}, 4'hF, rd);
    end
    p1_upper_pending_in <= UP[i];
    port_ready_in <= RDY[i];
    for (k = 0; k < 4; k++) cnt[k] = 0;
    for (k = 0; k < 2 * P && (cyc_cnt % P) != 4; k++) @(posedge ref_clk_in);
    queue_pending_in <= 4'hF;
    counting <= 1'b1;
    repeat (100) @(posedge ref_clk_in);
    queue_pending_in <= 4'h0;
    repeat (4) @(posedge ref_clk_in);
    counting <= 1'b0;
    // Still inside the same period, so the status word holds this window's grants.
    if (i == 0) begin
      wb_xfer(1'b0, 12'h380, 32'h0, 4'hF, rd);
      check(rd, 32'h0101_0101);
    end
    for (k = 0; k < 4; k++) begin
      if (EXP[i][k] == 8'hFF) check(32'(cnt[k] > 8), 32'h1);
      else check(32'(cnt[k]), {24'h0, EXP[i][k]});
    end
  endtask

  // Main sequence: reset, register defaults, scheduling modes, then field access.
  initial begin
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    wb_xfer(1'b0, 12'h328, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_8182);
    wb_xfer(1'b0, 12'h330, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_8488);
    for (int i = 0; i < 5; i++) run_cfg(i);
    wb_xfer(1'b1, 12'h328, 32'h0000_FFFF, 4'h1, rd);
    wb_xfer(1'b0, 12'h328, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_81FF);
    wb_xfer(1'b1, 12'h330, 32'hFFFF_7F7F, 4'hF, rd);
    wb_xfer(1'b0, 12'h330, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_7F7F);
    wb_xfer(1'b0, 12'h100, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    test_done;
  end
endmodule
